// ### rfsf_pkg.sv
// Package with register map, field positions and timing counts.
package rfsf_pkg;
    // Register indices; the bus byte address is four times the index.
    localparam logic [7:0] RFSF_IDX_OPTION    = 8'h10;
    localparam logic [7:0] RFSF_IDX_RXSTATUS  = 8'h11;
    localparam logic [7:0] RFSF_IDX_IRQ_STAT  = 8'h12;
    localparam logic [7:0] RFSF_IDX_IRQ_MASK  = 8'h13;
    localparam int         RFSF_ADDR_W        = 12;

    // Protocol option control fields.
    localparam int RFSF_OPT_COL6    = 0;
    localparam int RFSF_OPT_NFRAME  = 1;
    localparam int RFSF_OPT_SHORTRX = 2;
    localparam int RFSF_OPT_DIRECT  = 3;
    localparam int RFSF_OPT_GRID37  = 4;
    localparam int RFSF_OPT_NOPAR   = 5;
    localparam logic [7:0] RFSF_OPT_WMASK = 8'h3F;
    localparam logic [7:0] RFSF_OPT_RESET = 8'h00;

    // Receive status and interrupt fields.
    localparam int RFSF_RXS_BUSY    = 0;
    localparam int RFSF_IRQ_RXDONE  = 0;
    localparam int RFSF_IRQ_COLL    = 1;
    localparam int RFSF_IRQ_PARITY  = 2;
    localparam int RFSF_IRQ_SHORT   = 3;
    localparam int RFSF_IRQ_W       = 4;
    localparam logic [3:0] RFSF_IRQ_RESET = 4'h0;

    // Protocol constants.
    localparam logic [3:0] RFSF_COLL_PULSES7 = 4'h7;
    localparam logic [3:0] RFSF_COLL_PULSES6 = 4'h6;
    localparam logic [7:0] RFSF_SEL_CL1      = 8'h93;
    localparam logic [7:0] RFSF_SEL_CL2      = 8'h95;
    localparam logic [7:0] RFSF_SEL_CL3      = 8'h97;
    localparam logic [3:0] RFSF_SHORT_BITS   = 4'h4;

    // Timing.
    localparam int RFSF_CLK_MHZ       = 100;
    localparam int RFSF_BIT_RATE_KBPS = 106;
    localparam int RFSF_GRID18_PS     = 18880000;
    localparam int RFSF_GRID37_PS     = 37770000;
    localparam int RFSF_BIT_CYCLES = RFSF_CLK_MHZ * 1000 / RFSF_BIT_RATE_KBPS;
    localparam int RFSF_HALF_CYCLES   = RFSF_BIT_CYCLES / 2;
    localparam int RFSF_GRID18_CYCLES = RFSF_GRID18_PS / 1000 * RFSF_CLK_MHZ
                                        / 1000;
    localparam int RFSF_GRID37_CYCLES = RFSF_GRID37_PS / 1000 * RFSF_CLK_MHZ
                                        / 1000;

    localparam logic [1:0] RFSF_RESP_OKAY   = 2'h0;
    localparam logic [1:0] RFSF_RESP_SLVERR = 2'h2;
endpackage

// ### rfsf_top.sv
// Special-function register bank and its protocol option logic.
// Functional notes
// - Option bit 0 sets collision threshold: zero seven pulses, one six.
// - 0x93/0x95/0x97 frames: anticollision if framing bit 0, else normal.
// - Short-reply bit one accepts four-bit replies; zero, normal receive.
// - Direct bit feeds the external bit stream to the encoder, not FIFO.
// - Slot grid bit selects 18.88 us or 37.77 us marker grid.
// - Parity disable bit one switches off parity checking.
// - Receive status bit 0 mirrors the receive busy state (rx_in_progress).
// - Receive busy rises on decoded start of frame; completion interrupts.
// - Software reads receive busy without touching interrupt status.
// - Every feature is off with its bit at zero; default behaviour then.
// - Direct mode drives bit clock on pin 5, takes data on pin 3.
`timescale 1ns/1ps
module rfsf_top
    import rfsf_pkg::*;
(
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [RFSF_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [RFSF_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    output logic                        irq,
    input  wire logic                   subcarrier_pulse,
    input  wire logic                   bit_period_end,
    input  wire logic                   first_byte_valid,
    input  wire logic [7:0]             first_byte,
    input  wire logic                   sof_decoded,
    input  wire logic                   rx_end,
    input  wire logic [3:0]             rx_bit_count,
    input  wire logic                   parity_fail,
    input  wire logic                   fifo_bit,
    input  wire logic                   fifo_bit_valid,
    input  wire logic                   slot_timer_run,
    input  wire logic                   io2_in,
    input  wire logic                   io3_in,
    output logic                        io5_out,
    output logic                        io5_oe,
    output logic                        collision_error,
    output logic                        anticoll_frame,
    output logic                        short_reply,
    output logic                        parity_error,
    output logic                        parity_check_on,
    output logic                        encoder_bit,
    output logic                        encoder_strobe,
    output logic                        slot_tick,
    output logic                        rx_in_progress
);
    logic [7:0]          option_q;
    logic [RFSF_IRQ_W-1:0] irq_stat;
    logic [RFSF_IRQ_W-1:0] irq_mask;
    logic [RFSF_IRQ_W-1:0] next_irq_stat;
    logic [RFSF_IRQ_W-1:0] irq_events;
    logic                aw_got;
    logic                w_got;
    logic [7:0]          wr_idx;
    logic [7:0]          wr_data;
    logic                wr_lane0;
    logic                wr_fire;
    logic [7:0]          rd_idx;
    logic                rd_fire;
    logic [31:0]         next_rdata;
    logic                rd_hit;
    logic [3:0]          pulse_cnt;
    logic [3:0]          coll_limit;
    logic [1:0]          pin_s1;
    logic [1:0]          pin_s2;
    logic [1:0]          pin_s3;
    logic [1:0]          pin_f;
    logic [9:0]          half_cnt;
    logic                direct_run;
    logic [11:0]         grid_cnt;
    logic [11:0]         grid_last;
    assign wr_fire    = aw_got && w_got && !s_axi_bvalid;
    assign rd_fire    = s_axi_arvalid && s_axi_arready;
    assign rd_idx     = s_axi_araddr[9:2];
    assign coll_limit = option_q[RFSF_OPT_COL6] ? RFSF_COLL_PULSES6
                                                : RFSF_COLL_PULSES7;
    assign direct_run = option_q[RFSF_OPT_DIRECT] && pin_f[0];
    assign grid_last  = option_q[RFSF_OPT_GRID37]
                        ? 12'(RFSF_GRID37_CYCLES - 1)
                        : 12'(RFSF_GRID18_CYCLES - 1);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            wr_idx        <= 8'h00;
            wr_data       <= 8'h00;
            wr_lane0      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RFSF_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got        <= 1'b1;
                wr_idx        <= s_axi_awaddr[9:2];
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got        <= 1'b1;
                wr_data      <= s_axi_wdata[7:0];
                wr_lane0     <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wr_idx == RFSF_IDX_OPTION || wr_idx == RFSF_IDX_RXSTATUS
                    || wr_idx == RFSF_IDX_IRQ_STAT
                    || wr_idx == RFSF_IDX_IRQ_MASK) begin
                    s_axi_bresp <= RFSF_RESP_OKAY;
                end else begin
                    s_axi_bresp <= RFSF_RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end
    // Only the low byte lane holds register bits; upper bits are reserved.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            option_q <= RFSF_OPT_RESET;
            irq_mask <= RFSF_IRQ_RESET;
        end else if (wr_fire && wr_lane0) begin
            if (wr_idx == RFSF_IDX_OPTION) begin
                option_q <= wr_data & RFSF_OPT_WMASK;
            end
            if (wr_idx == RFSF_IDX_IRQ_MASK) begin
                irq_mask <= wr_data[RFSF_IRQ_W-1:0];
            end
        end
    end
    always_comb begin
        next_rdata = 32'h0000_0000;
        rd_hit     = 1'b1;
        case (rd_idx)
            RFSF_IDX_OPTION:   next_rdata[7:0] = option_q;
            RFSF_IDX_RXSTATUS:
                next_rdata[RFSF_RXS_BUSY] = rx_in_progress;
            RFSF_IDX_IRQ_STAT: next_rdata[RFSF_IRQ_W-1:0] = irq_stat;
            RFSF_IDX_IRQ_MASK: next_rdata[RFSF_IRQ_W-1:0] = irq_mask;
            default:           rd_hit = 1'b0;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RFSF_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= rd_hit ? RFSF_RESP_OKAY : RFSF_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
    // A new event in the clearing read's cycle survives the clear.
    assign irq_events[RFSF_IRQ_RXDONE] = rx_end && rx_in_progress;
    assign irq_events[RFSF_IRQ_COLL]   = bit_period_end
                                         && pulse_cnt >= coll_limit;
    assign irq_events[RFSF_IRQ_PARITY] = parity_fail
                                         && !option_q[RFSF_OPT_NOPAR];
    assign irq_events[RFSF_IRQ_SHORT]  = rx_end && option_q[RFSF_OPT_SHORTRX]
                                         && rx_bit_count == RFSF_SHORT_BITS;
    always_comb begin
        next_irq_stat = irq_stat;
        if (rd_fire && rd_idx == RFSF_IDX_IRQ_STAT) begin
            next_irq_stat = '0;
        end
        next_irq_stat = next_irq_stat | irq_events;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= RFSF_IRQ_RESET;
            irq      <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq      <= |(next_irq_stat & irq_mask);
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_in_progress <= 1'b0;
        end else if (sof_decoded) begin
            rx_in_progress <= 1'b1;
        end else if (rx_end) begin
            rx_in_progress <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_cnt       <= 4'h0;
            collision_error <= 1'b0;
        end else begin
            collision_error <= irq_events[RFSF_IRQ_COLL];
            if (bit_period_end) begin
                pulse_cnt <= 4'h0;
            end else if (subcarrier_pulse && pulse_cnt != 4'hF) begin
                pulse_cnt <= pulse_cnt + 4'h1;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            anticoll_frame  <= 1'b0;
            short_reply     <= 1'b0;
            parity_error    <= 1'b0;
            parity_check_on <= 1'b1;
        end else begin
            if (first_byte_valid) begin
                anticoll_frame <= !option_q[RFSF_OPT_NFRAME]
                                  && (first_byte == RFSF_SEL_CL1
                                  || first_byte == RFSF_SEL_CL2
                                  || first_byte == RFSF_SEL_CL3);
            end
            short_reply     <= irq_events[RFSF_IRQ_SHORT];
            parity_error    <= irq_events[RFSF_IRQ_PARITY];
            parity_check_on <= !option_q[RFSF_OPT_NOPAR];
        end
    end
    // Pin inputs: bit 0 is transmit enable, bit 1 transmit data.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1 <= 2'h0;
            pin_s2 <= 2'h0;
            pin_s3 <= 2'h0;
            pin_f  <= 2'h0;
        end else begin
            pin_s1 <= {io3_in, io2_in};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            for (int i = 0; i < 2; i++) begin
                if (pin_s2[i] == pin_s3[i]) begin
                    pin_f[i] <= pin_s3[i];
                end
            end
        end
    end
    // The bit clock is made here, so no second clock domain is needed.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            half_cnt       <= 10'h000;
            io5_out        <= 1'b0;
            io5_oe         <= 1'b0;
            encoder_bit    <= 1'b0;
            encoder_strobe <= 1'b0;
        end else begin
            io5_oe         <= option_q[RFSF_OPT_DIRECT];
            encoder_strobe <= 1'b0;
            if (direct_run) begin
                if (half_cnt == 10'(RFSF_HALF_CYCLES - 1)) begin
                    half_cnt <= 10'h000;
                    io5_out  <= !io5_out;
                    if (!io5_out) begin
                        encoder_bit    <= pin_f[1];
                        encoder_strobe <= 1'b1;
                    end
                end else begin
                    half_cnt <= half_cnt + 10'h001;
                end
            end else begin
                half_cnt <= 10'h000;
                io5_out  <= 1'b0;
                if (!option_q[RFSF_OPT_DIRECT] && fifo_bit_valid) begin
                    encoder_bit    <= fifo_bit;
                    encoder_strobe <= 1'b1;
                end
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            grid_cnt  <= 12'h000;
            slot_tick <= 1'b0;
        end else begin
            slot_tick <= 1'b0;
            if (!slot_timer_run) begin
                grid_cnt <= 12'h000;
            end else if (grid_cnt >= grid_last) begin
                grid_cnt  <= 12'h000;
                slot_tick <= 1'b1;
            end else begin
                grid_cnt <= grid_cnt + 12'h001;
            end
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    coll_seven_a: assert property (bit_period_end && pulse_cnt == 4'h6
        && !option_q[RFSF_OPT_COL6] |=> !collision_error)
        else $error("Six pulses flagged with seven-pulse threshold.");
    coll_six_a: assert property (bit_period_end && pulse_cnt == 4'h6
        && option_q[RFSF_OPT_COL6] |=> collision_error)
        else $error("Six pulses missed with six-pulse threshold.");
    anticoll_sel_a: assert property (first_byte_valid
        && first_byte == RFSF_SEL_CL2
        |=> anticoll_frame == !$past(option_q[RFSF_OPT_NFRAME]))
        else $error("Anticollision framing wrong for select code.");
    short_rx_a: assert property (rx_end
        && rx_bit_count == RFSF_SHORT_BITS |=> short_reply
        == $past(option_q[RFSF_OPT_SHORTRX]))
        else $error("Short reply gating wrong.");
    fifo_path_a: assert property (!option_q[RFSF_OPT_DIRECT]
        && fifo_bit_valid |=> encoder_strobe
        && encoder_bit == $past(fifo_bit))
        else $error("FIFO bit not passed to encoder.");
    direct_pin_a: assert property (!option_q[RFSF_OPT_DIRECT]
        |=> !io5_oe && !io5_out)
        else $error("Bit clock driven outside direct mode.");
    direct_clk_a: assert property ($rose(io5_out)
        |-> io5_out [*8])
        else $error("Bit clock high phase too short.");
    slot_grid_a: assert property ($rose(slot_timer_run)
        && !option_q[RFSF_OPT_GRID37]
        |-> !slot_tick [*8])
        else $error("Slot tick too early after start.");
    parity_off_a: assert property (parity_fail
        && option_q[RFSF_OPT_NOPAR] |=> !parity_error)
        else $error("Parity error reported while disabled.");
    rx_busy_a: assert property (sof_decoded
        || (rx_in_progress && !rx_end) |=> rx_in_progress)
        else $error("Receive busy did not hold after start.");
    rx_done_a: assert property (rx_end && rx_in_progress
        && !sof_decoded |=> !rx_in_progress && irq_stat[RFSF_IRQ_RXDONE])
        else $error("Receive completion not flagged.");
    rsvd_zero_a: assert property (rd_fire && rd_idx == RFSF_IDX_OPTION
        |=> s_axi_rvalid && s_axi_rdata[31:6] == 26'h0)
        else $error("Reserved option bits read nonzero.");

    direct_tx_c: cover property (encoder_strobe && direct_run);
    short_rx_c: cover property (short_reply);
    irq_clear_c: cover property (irq ##[1:20] !irq);
endmodule

// ### rfsf_host_model.sv
// Host model that drives the direct transmit pins from a byte pattern.
`timescale 1ns/1ps
module rfsf_host_model (
    input  wire logic       aclk,
    input  wire logic       go,
    input  wire logic [7:0] pattern,
    input  wire logic       bit_clk,
    output logic            tx_enable,
    output logic            tx_data
);
    logic [7:0] shift = 8'h00;
    logic [3:0] left = 4'h0;
    logic       clk_q = 1'b0;
    initial tx_enable = 1'b0;
    initial tx_data = 1'b0;
    always @(posedge aclk) begin
        clk_q <= bit_clk;
        if (go) begin
            tx_enable <= 1'b1;
            tx_data <= pattern[7];
            shift <= pattern;
            left <= 4'h8;
        end else if (clk_q && !bit_clk && left != 4'h0) begin
            // Data moves on the falling edge, away from the sampling edge.
            left <= left - 4'h1;
            shift <= {shift[6:0], 1'b0};
            // Released data shows the inverse, never a stale copy.
            tx_data <= (left == 4'h1) ? !tx_data : shift[6];
            if (left == 4'h1) tx_enable <= 1'b0;
        end
    end
endmodule

// ### tb_rfsf_top.sv
// Self-checking bench for the special-function register bank.
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
    miscompares++; $display("mismatch t=%0t got=%0h exp=%0h", \
    $time, (a), (e)); end end
module tb_rfsf_top
    import rfsf_pkg::*;
;
    localparam logic [11:0] A_OPT = {2'b00, RFSF_IDX_OPTION, 2'b00};
    localparam logic [11:0] A_RXS = {2'b00, RFSF_IDX_RXSTATUS, 2'b00};
    localparam logic [11:0] A_IST = {2'b00, RFSF_IDX_IRQ_STAT, 2'b00};
    localparam logic [11:0] A_IMK = {2'b00, RFSF_IDX_IRQ_MASK, 2'b00};
    localparam logic [6:0] E_SUB = 7'h40, E_BPE = 7'h20, E_SOF = 7'h10;
    localparam logic [6:0] E_END = 7'h08, E_PAR = 7'h04, E_FB = 7'h02;
    localparam logic [6:0] E_FIFO = 7'h01;
    // Grid lengths in 10 ns cycles: 18.88 us and 37.77 us.
    localparam int G18 = 1888, G37 = 3777, SPAN = 4 * G18 - 20;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, go;
    logic [RFSF_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, rx_bit_count;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic subcarrier_pulse, bit_period_end, first_byte_valid, sof_decoded;
    logic rx_end, parity_fail, fifo_bit, fifo_bit_valid, slot_timer_run;
    logic io2_in, io3_in, io5_out, io5_oe, collision_error, anticoll_frame;
    logic short_reply, parity_error, parity_check_on, encoder_bit;
    logic encoder_strobe, slot_tick, rx_in_progress;
    logic [7:0] first_byte, cap, pat, rd;
    logic [6:0] evs;
    int miscompares, total_checks, n_col, n_sh, n_par, n_slot, n_enc, n0;
    assign {subcarrier_pulse, bit_period_end, sof_decoded, rx_end,
            parity_fail, first_byte_valid, fifo_bit_valid} = evs;
    rfsf_top i_dut (.*);
    rfsf_host_model i_host (.aclk(aclk), .go(go), .pattern(pat),
        .bit_clk(io5_out), .tx_enable(io2_in), .tx_data(io3_in));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Output pulses are counted so checks do not hinge on exact latency.
    always @(posedge aclk) begin
        n_col <= n_col + int'(collision_error === 1'b1);
        n_sh <= n_sh + int'(short_reply === 1'b1);
        n_par <= n_par + int'(parity_error === 1'b1);
        n_slot <= n_slot + int'(slot_tick === 1'b1);
        if (encoder_strobe === 1'b1) begin
            cap <= {cap[6:0], encoder_bit};
            n_enc <= n_enc + 1;
        end
    end
    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic ev(input logic [6:0] m);
        @(posedge aclk);
        evs <= m;
        @(posedge aclk);
        evs <= 7'h00;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin do @(posedge aclk); while (s_axi_awready !== 1'b1);
                s_axi_awvalid <= 1'b0; end
            begin do @(posedge aclk); while (s_axi_wready !== 1'b1);
                s_axi_wvalid <= 1'b0; end
        join
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdr(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata[7:0];
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic t_reset();
        rdr(A_OPT);
        `CHK(rd, 8'h00)
        rdr(A_RXS);
        `CHK(rd, 8'h00)
        `CHK(parity_check_on, 1'b1)
        rdr(12'h3FC);
        `CHK(rsp, RFSF_RESP_SLVERR)
        $display("test reset done");
    endtask
    task automatic t_opt();
        wr(A_OPT, 8'hFF);
        `CHK(rsp, RFSF_RESP_OKAY)
        rdr(A_OPT);
        `CHK(rd, 8'h3F)
        `CHK(parity_check_on, 1'b0)
        ev(E_PAR);
        wr(A_OPT, 8'h00);
        ev(E_PAR);
        wt(3);
        `CHK(n_par, 1)
        rdr(A_IST);
        `CHK(rd, 8'h04)
        wr(12'h3FC, 8'hFF);
        `CHK(rsp, RFSF_RESP_SLVERR)
        $display("test option done");
    endtask
    task automatic coll(input logic [7:0] o, input int n, input int e);
        wr(A_OPT, o);
        repeat (n) ev(E_SUB);
        ev(E_BPE);
        wt(3);
        `CHK(n_col, e)
    endtask
    task automatic t_coll();
        wr(A_IMK, 8'h02);
        rdr(A_IMK);
        `CHK(rd, 8'h02)
        coll(8'h00, 6, 0);
        `CHK(irq, 1'b0)
        coll(8'h00, 7, 1);
        `CHK(irq, 1'b1)
        rdr(A_IST);
        `CHK(rd, 8'h02)
        wt(2);
        `CHK(irq, 1'b0)
        coll(8'h01, 6, 2);
        $display("test collision done");
    endtask
    task automatic t_frame();
        logic [7:0] codes[4] = '{8'h93, 8'h95, 8'h97, 8'h50};
        foreach (codes[i]) begin
            first_byte <= codes[i];
            wr(A_OPT, 8'h00);
            ev(E_FB);
            wt(2);
            `CHK(anticoll_frame, i < 3)
            wr(A_OPT, 8'h02);
            ev(E_FB);
            wt(2);
            `CHK(anticoll_frame, 1'b0)
        end
        $display("test framing done");
    endtask
    task automatic shrt(input logic [7:0] o, input logic [3:0] b, int e);
        wr(A_OPT, o);
        rx_bit_count <= b;
        ev(E_SOF);
        ev(E_END);
        wt(3);
        `CHK(n_sh, e)
    endtask
    task automatic t_rx();
        shrt(8'h00, 4'h4, 0);
        shrt(8'h04, 4'h4, 1);
        shrt(8'h04, 4'h8, 1);
        wr(A_IMK, 8'h01);
        rdr(A_IST);
        ev(E_SOF);
        wt(2);
        `CHK(rx_in_progress, 1'b1)
        rdr(A_RXS);
        `CHK(rd, 8'h01)
        `CHK(irq, 1'b0)
        ev(E_END);
        wt(3);
        `CHK(rx_in_progress, 1'b0)
        `CHK(irq, 1'b1)
        rdr(A_IST);
        `CHK(rd[0], 1'b1)
        $display("test receive done");
    endtask
    task automatic t_grid();
        for (int g = 0; g < 2; g++) begin
            wr(A_OPT, g ? 8'h10 : 8'h00);
            n0 = n_slot;
            slot_timer_run <= 1'b1;
            wt(SPAN);
            slot_timer_run <= 1'b0;
            wt(2);
            `CHK(n_slot - n0, SPAN / (g ? G37 : G18))
        end
        $display("test grid done");
    endtask
    task automatic t_direct();
        wr(A_OPT, 8'h08);
        wt(2);
        `CHK(io5_oe, 1'b1)
        n0 = n_enc;
        pat <= 8'hB4;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        ev(E_FIFO);
        wt(9 * 942);
        `CHK(cap, 8'hB4)
        `CHK(n_enc - n0, 8)
        wr(A_OPT, 8'h00);
        wt(2);
        `CHK(io5_oe, 1'b0)
        fifo_bit <= 1'b1;
        ev(E_FIFO);
        wt(3);
        `CHK(n_enc - n0, 9)
        `CHK(cap[0], 1'b1)
        $display("test direct done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #400000;
        miscompares++;
        finish_test();
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, go, slot_timer_run} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {rx_bit_count, first_byte, pat, evs, fifo_bit} = '0;
        {n_col, n_sh, n_par, n_slot, n_enc, cap} = '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_opt();
        t_coll();
        t_frame();
        t_rx();
        t_grid();
        t_direct();
        wr(A_OPT, 8'h00);
        aresetn <= 1'b0;
        wt(16);
        aresetn <= 1'b1;
        t_reset();
        finish_test();
    end
endmodule
